// *** hw/slpctl_defines.svh ***
// Offsets, field positions, reset values and timing counts of the sleep
// controller. Assumes inclusion by bare name from each design file.
`ifndef SLPCTL_DEFINES_SVH
`define SLPCTL_DEFINES_SVH

`define SLPCTL_CTRL_OFFSET 12'h000
`define SLPCTL_STAT_OFFSET 12'h004
`define SLPCTL_CTRL_RESET 8'h00
`define SLPCTL_ARM_BIT 0
`define SLPCTL_MODE_LSB 1
`define SLPCTL_MODE_MSB 3
`define SLPCTL_CTRL_MASK 8'h0F
`define SLPCTL_MODE_IDLE 3'h0
`define SLPCTL_MODE_NOISE 3'h1
`define SLPCTL_MODE_PDOWN 3'h2
`define SLPCTL_MODE_PSAVE 3'h3
`define SLPCTL_MODE_STBY 3'h6
`define SLPCTL_HOLD_CYCLES 3'h4
`define SLPCTL_STARTUP_CYCLES 8'h10

`endif

// *** hw/slpctl_pkg.sv ***
// Types shared by the sleep controller files.
// Assumes slpctl_defines.svh is on the include path.
package slpctl_pkg;
    // Sleep controller sequencing states
    typedef enum logic [2:0] {
        SLPCTL_RUN,
        SLPCTL_SLEEP,
        SLPCTL_STARTUP,
        SLPCTL_HOLD
    } slpctl_state_e;

    // Decoded sleep mode, one-hot
    typedef struct packed {
        logic idle;
        logic noise;
        logic pdown;
        logic psave;
        logic stby;
    } slpctl_mode_s;

    // Core-facing control outputs
    typedef struct packed {
        logic halt;
        logic resumeIrq;
        logic resetVector;
    } slpctl_core_s;
endpackage

// *** hw/slpctl_wake_timer.sv ***
// Wake timer: counts start-up time, then the extra halt cycles.
// Assumes a single clock and synchronous active-high reset.
`include "slpctl_defines.svh"
module slpctl_wake_timer (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic start,
    output logic startupDone,
    output logic holdDone
);
    import slpctl_pkg::*;

    logic [7:0] startCnt_q;
    logic [2:0] holdCnt_q;
    logic inStart_q;
    logic inHold_q;

    // Start-up count, then hold count
    always_ff @(posedge clk) begin
        if (sys_rst || start) begin
            startCnt_q <= 8'h00;
            holdCnt_q <= 3'h0;
            inStart_q <= start;
            inHold_q <= 1'b0;
        end else if (inStart_q) begin
            if (startCnt_q == `SLPCTL_STARTUP_CYCLES - 8'h01) begin
                inStart_q <= 1'b0;
                inHold_q <= 1'b1;
            end else begin
                startCnt_q <= startCnt_q + 8'h01;
            end
        end else if (inHold_q) begin
            if (holdCnt_q == `SLPCTL_HOLD_CYCLES - 3'h1) begin
                inHold_q <= 1'b0;
            end else begin
                holdCnt_q <= holdCnt_q + 3'h1;
            end
        end
    end

    assign startupDone = inStart_q &&
        (startCnt_q == `SLPCTL_STARTUP_CYCLES - 8'h01);
    assign holdDone = inHold_q && (holdCnt_q == `SLPCTL_HOLD_CYCLES - 3'h1);
endmodule

// *** hw/slpctl_top.sv ***
// Sleep mode controller: control register on APB, sleep sequencing.
// Assumes the core pulses sleepInstr, gives enabled-interrupt level
// irqPending, and restarts from its reset vector on sys_rst.
//
// Notes on behaviour
// [R1] Sleep entered only if arm bit is one when sleep instruction runs.
// [R2] Mode bits 3..1: 000 idle,001 noise,010 pdown,011 psave,110 standby.
// [R3] Any enabled interrupt during sleep wakes the device.
// [R4] After wake, core halted start-up plus four cycles, then runs handler.
// [R5] Register file and data memory are kept unchanged through sleep.
// [R6] Reset during sleep wakes and restarts at the reset vector.
// [R7] Control register bits 7..4 always read zero.
// [R8] Software picks standby only with crystal or resonator clock.
// [R9] Software arms sleep just before the instruction, clears after.
// [R10] Sleep instruction with arm bit zero does nothing.
`include "slpctl_defines.svh"
module slpctl_top (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic sleepInstr,
    input wire logic irqPending,
    output slpctl_pkg::slpctl_core_s coreCtl,
    output slpctl_pkg::slpctl_mode_s modeActive,
    output logic sleeping
);
    import slpctl_pkg::*;

    logic [7:0] ctrl_q;
    slpctl_state_e state_q;
    slpctl_mode_s modeActive_q;
    logic resumeIrq_q;
    logic resetVector_q;
    logic timerStart;
    logic startupDone;
    logic holdDone;
    logic apbAccess;
    logic ctrlHit;
    logic statHit;
    logic [7:0] stallCnt_q;

    // Decode mode field into one-hot; reserved codes give no mode
    function automatic slpctl_mode_s decodeMode(input logic [2:0] code);
        slpctl_mode_s m;
        m = '0;
        case (code)
            `SLPCTL_MODE_IDLE: m.idle = 1'b1;
            `SLPCTL_MODE_NOISE: m.noise = 1'b1;
            `SLPCTL_MODE_PDOWN: m.pdown = 1'b1;
            `SLPCTL_MODE_PSAVE: m.psave = 1'b1;
            `SLPCTL_MODE_STBY: m.stby = 1'b1;
            default: m = '0;
        endcase
        return m;
    endfunction

    // APB decode; zero wait states
    assign apbAccess = psel && penable;
    assign ctrlHit = paddr == `SLPCTL_CTRL_OFFSET;
    assign statHit = paddr == `SLPCTL_STAT_OFFSET;
    assign pready = 1'b1;
    assign pslverr = apbAccess && !ctrlHit && !statHit;

    // Control register; upper bits never stored
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            ctrl_q <= `SLPCTL_CTRL_RESET;
        end else if (apbAccess && pwrite && ctrlHit) begin
            ctrl_q <= pwdata[7:0] & `SLPCTL_CTRL_MASK; // R7
        end
    end

    // Read data register
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            prdata <= 32'h0000_0000;
        end else if (psel && !penable && !pwrite) begin
            if (paddr == `SLPCTL_CTRL_OFFSET) begin
                prdata <= {24'h000000, ctrl_q & `SLPCTL_CTRL_MASK}; // R7
            end else if (paddr == `SLPCTL_STAT_OFFSET) begin
                prdata <= {29'h0, resetVector_q, resumeIrq_q, sleeping};
            end else begin
                prdata <= 32'h0000_0000;
            end
        end
    end

    assign timerStart = (state_q == SLPCTL_SLEEP) && irqPending; // R3

    // Sleep sequencer; sys_rst ends any sleep at once
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state_q <= SLPCTL_RUN; // R6
            modeActive_q <= '0;
        end else begin
            case (state_q)
                SLPCTL_RUN: begin
                    if (sleepInstr && ctrl_q[`SLPCTL_ARM_BIT]) begin // R1
                        state_q <= SLPCTL_SLEEP;
                        modeActive_q <= decodeMode(
                            ctrl_q[`SLPCTL_MODE_MSB:`SLPCTL_MODE_LSB]); // R2
                    end // R10
                end
                SLPCTL_SLEEP: begin
                    if (irqPending) begin
                        state_q <= SLPCTL_STARTUP; // R3
                    end
                end
                SLPCTL_STARTUP: begin
                    modeActive_q <= '0;
                    if (startupDone) begin
                        state_q <= SLPCTL_HOLD; // R4
                    end
                end
                SLPCTL_HOLD: begin
                    if (holdDone) begin
                        state_q <= SLPCTL_RUN; // R4
                    end
                end
                default: state_q <= SLPCTL_RUN;
            endcase
        end
    end

    // Resume pulse to core after hold; reset-vector flag after reset
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            resumeIrq_q <= 1'b0;
            resetVector_q <= 1'b1; // R6
        end else begin
            resumeIrq_q <= (state_q == SLPCTL_HOLD) && holdDone; // R4
            resetVector_q <= 1'b0;
        end
    end

    slpctl_wake_timer u_timer (
        .clk(clk),
        .sys_rst(sys_rst),
        .start(timerStart),
        .startupDone(startupDone),
        .holdDone(holdDone)
    );

    // Halt stalls the core only; memories keep their state
    assign coreCtl.halt = state_q != SLPCTL_RUN; // R5
    assign coreCtl.resumeIrq = resumeIrq_q;
    assign coreCtl.resetVector = resetVector_q;
    assign modeActive = modeActive_q;
    assign sleeping = state_q == SLPCTL_SLEEP;

    // Cycles the core has stayed stalled since it left the sleep state
    always_ff @(posedge clk) begin
        if (sys_rst || sleeping || !coreCtl.halt) begin
            stallCnt_q <= 8'h00;
        end else if (stallCnt_q != 8'hFF) begin
            stallCnt_q <= stallCnt_q + 8'h01; // R4
        end
    end

    // Checks
    sequence seqWake;
        (state_q == SLPCTL_SLEEP) && irqPending;
    endsequence

    // Sleep instruction seen while running with the arm bit set
    sequence seqArmedSleep;
        state_q == SLPCTL_RUN && sleepInstr && ctrl_q[`SLPCTL_ARM_BIT];
    endsequence

    AST_ARM_ENTRY: assert property (@(posedge clk) disable iff (sys_rst) // R1
        (state_q == SLPCTL_RUN && sleepInstr && ctrl_q[0]) |=> sleeping)
        else $error("Armed sleep instruction did not enter sleep");
    AST_UNARMED: assert property (@(posedge clk) disable iff (sys_rst) // R10
        (state_q == SLPCTL_RUN && sleepInstr && !ctrl_q[0]) |=> !sleeping)
        else $error("Unarmed sleep instruction entered sleep");
    AST_MODE: assert property (@(posedge clk) disable iff (sys_rst) // R2
        (state_q == SLPCTL_RUN && sleepInstr && ctrl_q[0]
            && ctrl_q[3:1] == 3'h6) |=> modeActive.stby)
        else $error("Standby code not decoded");
    AST_WAKE: assert property (@(posedge clk) disable iff (sys_rst) // R3
        seqWake |=> (state_q == SLPCTL_STARTUP))
        else $error("Interrupt did not wake");
    AST_HOLD: assert property (@(posedge clk) disable iff (sys_rst) // R4
        seqWake |=> ##19 (coreCtl.halt && stallCnt_q == 8'h13)
            ##1 (coreCtl.resumeIrq && !coreCtl.halt))
        else $error("Wake timing wrong");
    AST_HALTED: assert property (@(posedge clk) disable iff (sys_rst) // R5
        sleeping |-> coreCtl.halt)
        else $error("Core not halted while asleep");
    AST_RESET: assert property (@(posedge clk) // R6
        sys_rst |=> !coreCtl.halt && coreCtl.resetVector)
        else $error("Reset did not restart core");
    AST_UPPER: assert property (@(posedge clk) disable iff (sys_rst) // R7
        ctrl_q[7:4] == 4'h0)
        else $error("Upper control bits stored");

    // Control write keeps only the low nibble of the bus data
    AST_CTRL_WRITE: assert property (@(posedge clk) disable iff (sys_rst) // R7
        (apbAccess && pwrite && ctrlHit)
            |=> (ctrl_q == ($past(pwdata[7:0]) & `SLPCTL_CTRL_MASK)))
        else $error("Control write not stored as masked");

    // Reserved select codes still sleep, with no mode flag raised
    AST_RESERVED: assert property (@(posedge clk) disable iff (sys_rst) // R2
        seqArmedSleep ##0 (ctrl_q[3:1] inside {3'h4, 3'h5, 3'h7})
            |=> (sleeping && modeActive == '0))
        else $error("Reserved code raised a mode flag");

    // Mode flags drop once start-up begins
    AST_MODE_CLEAR: assert property (@(posedge clk) disable iff (sys_rst) // R3
        (state_q == SLPCTL_STARTUP) |=> (modeActive == '0))
        else $error("Mode flag kept after wake");

    // Resume is a single-cycle pulse
    AST_RESUME_ONCE: assert property (@(posedge clk) disable iff (sys_rst) // R4
        coreCtl.resumeIrq |=> !coreCtl.resumeIrq)
        else $error("Resume pulse longer than one cycle");

    // Reset in sleep restarts from the reset vector, not the routine
    AST_RESET_WAKE: assert property (@(posedge clk) // R6
        (sys_rst && sleeping) |=> (!sleeping && coreCtl.resetVector
            && !coreCtl.resumeIrq))
        else $error("Reset in sleep did not restart from reset vector");
endmodule

// *** tb/slpctl_core_model.sv ***
// Behavioural processor core: issues sleep, raises enabled interrupts.
// Assumes the controller's halt and resume outputs on the same clock.
module slpctl_core_model
    import slpctl_pkg::*;
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic doSleep,
    input wire logic wakeReq,
    input slpctl_pkg::slpctl_core_s coreCtl,
    output logic sleepInstr,
    output logic irqPending
);
    // One-cycle sleep instruction, never issued while stalled
    always @(posedge clk) begin
        sleepInstr <= doSleep && !coreCtl.halt && !sys_rst;
    end
    // Interrupt stays pending until its routine runs
    always @(posedge clk) begin
        if (sys_rst || coreCtl.resumeIrq) begin
            irqPending <= 1'b0;
        end else if (wakeReq) begin
            irqPending <= 1'b1;
        end
    end
endmodule

// *** tb/tb_top.sv ***
// Self-checking bench of the sleep controller: APB master and core model.
// Assumes the designer's start-up and hold counts from the defines.
`include "slpctl_defines.svh"
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import slpctl_pkg::*;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rdData, wv;
    logic pready, pslverr, sleepInstr, irqPending, sleeping, rdErr;
    logic doSleep = 1'b0, wakeReq = 1'b0;
    slpctl_core_s coreCtl;
    slpctl_mode_s modeActive;
    int fail_count = 0, num_checks = 0;

    slpctl_top DUT (.clk(clk), .sys_rst(sys_rst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .sleepInstr(sleepInstr), .irqPending(irqPending),
        .coreCtl(coreCtl), .modeActive(modeActive), .sleeping(sleeping));
    slpctl_core_model uCore (.clk(clk), .sys_rst(sys_rst), .doSleep(doSleep),
        .wakeReq(wakeReq), .coreCtl(coreCtl), .sleepInstr(sleepInstr),
        .irqPending(irqPending));

    // 40 MHz clock
    initial begin
        forever #12.5 clk = ~clk;
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("wrong value at %0t: saw %h, want %h", $time, seen, exp);
        end
    endtask

    task automatic stop_test();
        $display("checks %0d, mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // One APB transfer; read data and error taken at the pready edge
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rdData = prdata;
        rdErr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // Expected one-hot flags {idle,noise,pdown,psave,stby}
    function automatic logic [4:0] expMode(input logic [2:0] m);
        case (m)
            `SLPCTL_MODE_IDLE: return 5'h10;
            `SLPCTL_MODE_NOISE: return 5'h08;
            `SLPCTL_MODE_PDOWN: return 5'h04;
            `SLPCTL_MODE_PSAVE: return 5'h02;
            `SLPCTL_MODE_STBY: return 5'h01;
            default: return 5'h00;
        endcase
    endfunction

    task automatic sleepCmd();
        @(posedge clk) doSleep <= 1'b1;
        @(posedge clk) doSleep <= 1'b0;
        repeat (3) @(negedge clk);
    endtask

    // Raise an interrupt, time the stall until the routine resumes
    task automatic wakeAndTime();
        int n;
        @(posedge clk) wakeReq <= 1'b1;
        @(posedge clk) wakeReq <= 1'b0;
        n = 0;
        while (irqPending !== 1'b1 && n < 8) begin
            @(negedge clk);
            n++;
        end
        n = 0;
        while (coreCtl.resumeIrq !== 1'b1 && n < 100) begin
            chk(coreCtl.halt, 1'b1);
            @(negedge clk);
            n++;
        end
        chk(n, `SLPCTL_STARTUP_CYCLES + `SLPCTL_HOLD_CYCLES + 1);
        chk(coreCtl.halt, 1'b0);
        chk(sleeping, 1'b0);
        @(negedge clk);
        chk(coreCtl.resumeIrq, 1'b0);
    endtask

    // Main sequence
    initial begin
        void'($urandom(32'h2CBD));
        repeat (8) @(posedge clk);
        sys_rst <= 1'b0;
        apb(1'b0, `SLPCTL_CTRL_OFFSET, 32'h0);
        chk(rdData, 32'h0);
        apb(1'b1, 12'h008, 32'hF);
        chk(rdErr, 1'b1);
        apb(1'b0, 12'h008, 32'h0);
        chk(rdData, 32'h0);
        // All-ones corner, then random control writes: upper bits never stick
        apb(1'b1, `SLPCTL_CTRL_OFFSET, 32'hFFFF_FFFF);
        apb(1'b0, `SLPCTL_CTRL_OFFSET, 32'h0);
        chk(rdData, 32'h0000_000F);
        repeat (6) begin
            wv = $urandom();
            apb(1'b1, `SLPCTL_CTRL_OFFSET, wv);
            chk(rdErr, 1'b0);
            apb(1'b0, `SLPCTL_CTRL_OFFSET, 32'h0);
            chk(rdData, wv & 32'h0000000F);
        end
        // Unarmed sleep instruction is ignored
        apb(1'b1, `SLPCTL_CTRL_OFFSET, 32'h4);
        sleepCmd();
        chk(sleeping, 1'b0);
        chk(coreCtl.halt, 1'b0);
        // Every select code armed, then woken after a random delay
        for (int m = 0; m < 8; m++) begin
            apb(1'b1, `SLPCTL_CTRL_OFFSET, {28'h0, m[2:0], 1'b1});
            sleepCmd();
            chk(sleeping, 1'b1);
            chk(modeActive, expMode(m[2:0]));
            apb(1'b0, `SLPCTL_STAT_OFFSET, 32'h0);
            chk(rdData, 32'h0000_0001);
            repeat ($urandom_range(0, 5)) @(posedge clk);
            wakeAndTime();
            chk(modeActive, 5'h00);
            apb(1'b1, `SLPCTL_CTRL_OFFSET, 32'h0);
        end
        // Reset in mid-sleep restarts from the reset vector
        apb(1'b1, `SLPCTL_CTRL_OFFSET, 32'h5);
        sleepCmd();
        @(posedge clk) sys_rst <= 1'b1;
        repeat (2) @(negedge clk);
        chk(coreCtl.resetVector, 1'b1);
        chk(sleeping, 1'b0);
        @(posedge clk) sys_rst <= 1'b0;
        apb(1'b0, `SLPCTL_CTRL_OFFSET, 32'h0);
        chk(rdData, 32'h0);
        stop_test();
    end

    // Watchdog against a hang
    initial begin
        repeat (20000) @(posedge clk);
        fail_count++;
        stop_test();
    end
endmodule
